// file: verilog/amc_pkg.sv
// constants, register map and carrier types of the monitor power/mode control
// Overview of operation
// - writing one to trigger bit 0 in a low-power state starts one pass
// - after a triggered pass the device returns to its previous low-power state
// - deep-sleep enable bit 0 acts only while the run-enable bit is zero
// - any write to the advanced config clears readings
// - advanced config bit 0 picks internal 2.56V or external reference
// - activity register at 0Ch, bit 0 reads one while converting
// - activity bit 1 reads one until power-up completes; reset value 02h
// - shutdown means run-enable at 00h is zero; host clears it first
// - mode 2 slots hold pseudo-differential pairs, first in0+ against in1-
package amc_pkg;
    localparam logic [7:0] AMC_ADDR_CONFIG = 8'h00;
    localparam logic [7:0] AMC_ADDR_ACTIVITY = 8'h0c;
    localparam logic [7:0] AMC_ADDR_DEEP_SLEEP = 8'h0a;
    localparam logic [7:0] AMC_ADDR_ADV_CONFIG = 8'h0b;
    localparam logic [7:0] AMC_ADDR_TRIGGER = 8'h09;
    localparam int AMC_RUN_BIT = 0;
    localparam int AMC_TRIGGER_BIT = 0;
    localparam int AMC_DEEP_BIT = 0;
    localparam int AMC_EXT_REF_BIT = 0;
    localparam int AMC_LAYOUT_LSB = 1;
    localparam int AMC_BUSY_BIT = 0;
    localparam int AMC_NOT_READY_BIT = 1;
    localparam logic [7:0] AMC_CONFIG_RESET = 8'h00;
    localparam logic [7:0] AMC_DEEP_RESET = 8'h00;
    localparam logic [7:0] AMC_ADV_RESET = 8'h00;
    localparam logic [7:0] AMC_ACTIVITY_RESET = 8'h02;
    localparam int AMC_POWERUP_CYCLES = 64;
    localparam int AMC_PASS_CYCLES = 32;

    typedef enum logic [1:0] {
        AMC_MODE_SINGLE,
        AMC_MODE_ALL_SINGLE,
        AMC_MODE_PSEUDO_DIFF,
        AMC_MODE_MIXED
    } amc_layout_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } amc_req_type;

    typedef struct packed {
        logic ext_ref;
        amc_layout_type layout;
        logic clear_results;
        logic deep_sleep;
        logic shutdown;
    } amc_ctrl_type;
endpackage : amc_pkg

// file: verilog/amc_pass_timer.sv
// conversion pass sequencer: counts one pass length after a start
`timescale 1ns/100ps
module amc_pass_timer
    import amc_pkg::*;
#(
    parameter int PASS_CYCLES = AMC_PASS_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    output logic busy,
    output logic done
);
    localparam int CW = $clog2(PASS_CYCLES + 1);
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic busy_q;
    logic done_q;
    wire last_w = busy_q && (count_q == CW'(PASS_CYCLES - 1));

    assign count_d = start ? '0 : (busy_q ? count_q + CW'(1) : count_q);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            count_q <= count_d;
            busy_q <= start | (busy_q & ~last_w);
            done_q <= last_w & ~start;
        end
    end

    assign busy = busy_q;
    assign done = done_q;
endmodule : amc_pass_timer

// file: verilog/amc_power_mode_ctrl.sv
// register front end and power-state control of the monitoring converter
`timescale 1ns/100ps
module amc_power_mode_ctrl
    import amc_pkg::*;
#(
    parameter int POWERUP_CYCLES = AMC_POWERUP_CYCLES,
    parameter int PASS_CYCLES = AMC_PASS_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire amc_req_type req,
    output logic [7:0] rdata,
    output logic rvalid,
    output amc_ctrl_type ctrl,
    output logic pass_active,
    output logic pass_done,
    output logic [2:0] slot0_pos_input,
    output logic [2:0] slot0_neg_input,
    output logic slot0_is_pair
);
    typedef enum logic [2:0] {
        AMC_ST_POWERUP,
        AMC_ST_SHUTDOWN,
        AMC_ST_DEEP,
        AMC_ST_RUN,
        AMC_ST_ONESHOT
    } amc_state_type;

    // counter wide enough to reach the power-up count itself
    localparam int PW = $clog2(POWERUP_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////
    // registers
    amc_state_type state_q, state_d;
    amc_state_type return_q, return_d;
    logic [7:0] config_q;
    logic [7:0] deep_q;
    logic [7:0] adv_q;
    logic [PW-1:0] pwr_cnt_q;
    logic ready_q;
    logic [7:0] rdata_q;
    logic rvalid_q;
    amc_ctrl_type ctrl_q;
    logic clear_q;
    logic pstart_q;
    logic pdone_q;
    logic [2:0] pos_q, neg_q;
    logic pair_q;

    ////////////////////////////////////////////////////////////////////////
    // decode
    // a write strobe aimed at one register offset
    function automatic logic wr_hit(input amc_req_type r,
                                    input logic [7:0] a);
        return r.wr && r.addr == a;
    endfunction : wr_hit

    // one access a cycle, so at most one of these strobes is high
    wire wr_cfg = wr_hit(req, AMC_ADDR_CONFIG);
    wire wr_deep = wr_hit(req, AMC_ADDR_DEEP_SLEEP);
    wire wr_adv = wr_hit(req, AMC_ADDR_ADV_CONFIG);
    wire wr_trig = wr_hit(req, AMC_ADDR_TRIGGER);
    wire run_w = config_q[AMC_RUN_BIT];
    wire deep_en_w = deep_q[AMC_DEEP_BIT];
    wire low_power_w = state_q == AMC_ST_SHUTDOWN || state_q == AMC_ST_DEEP;
    wire trig_w = wr_trig && req.wdata[AMC_TRIGGER_BIT] && low_power_w;
    // pass timer outputs, both straight from flops inside the timer
    wire busy_w;
    wire done_w;
    amc_layout_type layout_w;
    assign layout_w = amc_layout_type'(adv_q[AMC_LAYOUT_LSB +: 2]);
    wire pdiff_w = layout_w == AMC_MODE_PSEUDO_DIFF;

    // reserved activity bits are tied low
    wire [7:0] activity_w = {6'h00, ~ready_q, busy_w};
    wire [7:0] rd_mux_w =
        req.addr == AMC_ADDR_CONFIG ? config_q :
        req.addr == AMC_ADDR_DEEP_SLEEP ? {7'h00, deep_en_w} :
        req.addr == AMC_ADDR_ADV_CONFIG ? {5'h00, adv_q[2:0]} :
        req.addr == AMC_ADDR_ACTIVITY ? activity_w : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // state machine
    // powerup holds until the not-ready flag clears; run wins over deep
    // sleep; a trigger from either low-power state runs one pass and then
    // returns to the state it left, whatever the run bit did meanwhile
    always_comb begin
        state_d = state_q;
        return_d = return_q;
        unique case (state_q)
            AMC_ST_POWERUP: begin
                if (ready_q) begin
                    state_d = AMC_ST_SHUTDOWN;
                end
            end
            AMC_ST_SHUTDOWN, AMC_ST_DEEP: begin
                if (trig_w) begin
                    return_d = state_q;
                    state_d = AMC_ST_ONESHOT;
                end else if (run_w) begin
                    state_d = AMC_ST_RUN;
                end else if (deep_en_w) begin
                    state_d = AMC_ST_DEEP;
                end else begin
                    state_d = AMC_ST_SHUTDOWN;
                end
            end
            AMC_ST_RUN: begin
                if (!run_w && !busy_w) begin
                    state_d = deep_en_w ? AMC_ST_DEEP : AMC_ST_SHUTDOWN;
                end
            end
            AMC_ST_ONESHOT: begin
                if (done_w) begin
                    state_d = return_q;
                end
            end
            default: state_d = AMC_ST_SHUTDOWN;
        endcase
    end

    // continuous passes restart while running; one-shot starts once
    wire pstart_w = trig_w || (state_q == AMC_ST_RUN && run_w && !busy_w
                    && !pstart_q);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= AMC_ST_POWERUP;
            return_q <= AMC_ST_SHUTDOWN;
            pwr_cnt_q <= '0;
            ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            // return state only changes when a trigger is taken
            return_q <= return_d;
            // count freezes at ready, so not-ready cannot come back
            if (!ready_q) begin
                pwr_cnt_q <= pwr_cnt_q + PW'(1);
            end
            if (pwr_cnt_q == PW'(POWERUP_CYCLES - 1)) begin
                ready_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register file
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            config_q <= AMC_CONFIG_RESET;
            deep_q <= AMC_DEEP_RESET;
            adv_q <= AMC_ADV_RESET;
            clear_q <= 1'b0;
        end else begin
            if (wr_cfg) begin
                config_q <= req.wdata;
            end
            // reserved bits are stored as zero, so readback never shows them
            if (wr_deep) begin
                deep_q <= {7'h00, req.wdata[AMC_DEEP_BIT]};
            end
            if (wr_adv) begin
                adv_q <= {5'h00, req.wdata[2:0]};
            end
            // one stage of delay so the clear leaves with the new mode
            clear_q <= wr_adv;
        end
    end

    // one timer serves both the free-running and the single-pass starts
    amc_pass_timer #(
        .PASS_CYCLES(PASS_CYCLES)
    ) u_pass (
        .clk(clk),
        .rst_n(rst_n),
        .start(pstart_w),
        .busy(busy_w),
        .done(done_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // output flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
            ctrl_q <= '0;
            pstart_q <= 1'b0;
            pdone_q <= 1'b0;
            pos_q <= 3'h0;
            neg_q <= 3'h0;
            pair_q <= 1'b0;
        end else begin
            // read data holds between reads so a slow host may sample late
            rdata_q <= req.rd ? rd_mux_w : rdata_q;
            rvalid_q <= req.rd;
            ctrl_q.ext_ref <= adv_q[AMC_EXT_REF_BIT];
            ctrl_q.layout <= layout_w;
            ctrl_q.clear_results <= clear_q;
            // state flags lag the state by one cycle, like every output except pass_active
            ctrl_q.deep_sleep <= state_q == AMC_ST_DEEP;
            ctrl_q.shutdown <= state_q == AMC_ST_SHUTDOWN;
            pstart_q <= pstart_w;
            pdone_q <= done_w;
            // first slot in pseudo-differential mode pairs in0+ with in1-
            pair_q <= pdiff_w;
            pos_q <= 3'h0;
            neg_q <= pdiff_w ? 3'h1 : 3'h0;
        end
    end

    assign rdata = rdata_q;
    assign rvalid = rvalid_q;
    assign ctrl = ctrl_q;
    // a start raises busy at the same edge, so busy alone marks the pass
    assign pass_active = busy_w;
    assign pass_done = pdone_q;
    assign slot0_pos_input = pos_q;
    assign slot0_neg_input = neg_q;
    assign slot0_is_pair = pair_q;
endmodule : amc_power_mode_ctrl

// file: verification/amc_host_model.sv
// host model: drives register requests into the control block
`timescale 1ns/100ps
module amc_host_model
    import amc_pkg::*;
(
    input wire logic clk,
    output amc_req_type req,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    initial req = '0;
    // released lines show the inverse of the last request, not a stale copy
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        req <= '{1'b0, 1'b0, ~a, ~d};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic v);
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        req <= '{1'b0, 1'b0, ~a, 8'hff};
        @(posedge clk);
        d = rdata;
        v = rvalid;
    endtask : rd
endmodule : amc_host_model

// file: verification/amc_power_mode_ctrl_chk.sv
// assertion checker for the power and mode control block
`timescale 1ns/100ps
module amc_power_mode_ctrl_chk
    import amc_pkg::*;
#(
    parameter int POWERUP_CYCLES = AMC_POWERUP_CYCLES,
    parameter int PASS_CYCLES = AMC_PASS_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire amc_req_type req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire amc_ctrl_type ctrl,
    input wire logic pass_active,
    input wire logic pass_done,
    input wire logic [2:0] slot0_pos_input,
    input wire logic [2:0] slot0_neg_input,
    input wire logic slot0_is_pair
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire adv_wr = req.wr && req.addr == AMC_ADDR_ADV_CONFIG;
    wire trig_wr = req.wr && req.addr == AMC_ADDR_TRIGGER && req.wdata[0];
    wire act_rd = req.rd && req.addr == AMC_ADDR_ACTIVITY;
    wire low_pwr = ctrl.shutdown || ctrl.deep_sleep;
    logic [7:0] wd1_q;
    logic [7:0] wd2_q;
    logic run_q;
    // write data delayed to the cycle where the config outputs settle
    always_ff @(posedge clk) begin
        wd1_q <= req.wdata;
        wd2_q <= wd1_q;
    end
    // run bit as the host last wrote it; deep sleep starts only without it, except on return from a triggered pass
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'b0;
        end else if (req.wr && req.addr == AMC_ADDR_CONFIG) begin
            run_q <= req.wdata[AMC_RUN_BIT];
        end
    end
    ////////////////////////////////////////////////////////////////////
    property p_trig; trig_wr && low_pwr && !pass_active |=> pass_active;
    endproperty
    a_trig: assert property (p_trig) else $error("no pass started");
    property p_back; $rose(pass_active) && ctrl.deep_sleep |->
        ##[1:40] pass_done ##[0:2] ctrl.deep_sleep; endproperty
    a_back: assert property (p_back) else $error("sleep lost");
    property p_deep; $rose(ctrl.deep_sleep) |-> !$past(run_q, 2);
    endproperty
    a_deep: assert property (p_deep) else $error("bad sleep");
    property p_clear; adv_wr |-> ##2 ctrl.clear_results; endproperty
    a_clear: assert property (p_clear) else $error("no clear");
    property p_ref; adv_wr |-> ##2 ctrl.ext_ref == wd2_q[0]; endproperty
    a_ref: assert property (p_ref) else $error("bad reference");
    property p_layout; adv_wr |-> ##2 ctrl.layout == wd2_q[2:1]; endproperty
    a_layout: assert property (p_layout) else $error("bad layout");
    property p_slot; ctrl.layout == AMC_MODE_PSEUDO_DIFF |-> slot0_is_pair
        && slot0_pos_input == 3'h0 && slot0_neg_input == 3'h1; endproperty
    a_slot: assert property (p_slot) else $error("bad slot");
    property p_act; act_rd |=> rvalid && rdata[0] == $past(pass_active)
        && rdata[7:2] == 6'h00; endproperty
    a_act: assert property (p_act) else $error("bad activity");
    c_pass: cover property ($rose(pass_active));
    c_deep: cover property ($rose(ctrl.deep_sleep));
    c_clear: cover property (ctrl.clear_results);
endmodule : amc_power_mode_ctrl_chk

bind amc_power_mode_ctrl amc_power_mode_ctrl_chk #(
    .POWERUP_CYCLES(POWERUP_CYCLES), .PASS_CYCLES(PASS_CYCLES)
) chk_inst (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
    .rvalid(rvalid), .ctrl(ctrl), .pass_active(pass_active),
    .pass_done(pass_done), .slot0_pos_input(slot0_pos_input),
    .slot0_neg_input(slot0_neg_input), .slot0_is_pair(slot0_is_pair));

// file: verification/tb.sv
// self-checking bench for the power and mode control block
`timescale 1ns/100ps
module tb
    import amc_pkg::*;
();
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    amc_req_type req;
    logic [7:0] rdata, d;
    logic rvalid, v, pass_active, pass_done, slot0_is_pair;
    amc_ctrl_type ctrl;
    logic [2:0] slot0_pos_input, slot0_neg_input;
    int n_fail = 0;
    int n_compared = 0;
    int cycles = 0;
    // write data beside expected readback; ext_ref and layout ride in it
    logic [15:0] rows [4] = '{16'h0000, 16'h0303, 16'h0505, 16'hff07};
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            wrap_up();
        end
    end
    amc_power_mode_ctrl #(.POWERUP_CYCLES(4), .PASS_CYCLES(12))
    amc_power_mode_ctrl_inst (.clk(clk), .rst_n(rst_n), .req(req),
        .rdata(rdata), .rvalid(rvalid), .ctrl(ctrl),
        .pass_active(pass_active), .pass_done(pass_done),
        .slot0_pos_input(slot0_pos_input), .slot0_neg_input(slot0_neg_input),
        .slot0_is_pair(slot0_is_pair));
    amc_host_model amc_host_model_inst (.clk(clk), .req(req), .rdata(rdata),
        .rvalid(rvalid));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        amc_host_model_inst.rd(a, d, v);
        chk({7'h00, v}, 8'h01);
        chk(d, exp);
    endtask : rdc
    task automatic wr(input logic [7:0] a, input logic [7:0] dv);
        amc_host_model_inst.wr(a, dv);
        repeat (3) @(negedge clk);
    endtask : wr
    task automatic wait_pass;
        for (int i = 0; i < 50 && pass_done !== 1'b1; i++) @(negedge clk);
        chk({7'h00, pass_done}, 8'h01);
        repeat (3) @(negedge clk);
    endtask : wait_pass
    task automatic wrap_up;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rdc(AMC_ADDR_ACTIVITY, 8'h02);
        repeat (12) @(posedge clk);
        rdc(AMC_ADDR_ACTIVITY, 8'h00);
        $display("power-up test done");
        wr(AMC_ADDR_CONFIG, 8'h00);
        foreach (rows[i]) begin
            amc_host_model_inst.wr(AMC_ADDR_ADV_CONFIG, rows[i][15:8]);
            repeat (2) @(negedge clk);
            chk({7'h00, ctrl.clear_results}, 8'h01);
            @(negedge clk);
            chk({7'h00, ctrl.ext_ref}, {7'h00, rows[i][0]});
            chk({6'h00, ctrl.layout}, {6'h00, rows[i][2:1]});
            rdc(AMC_ADDR_ADV_CONFIG, rows[i][7:0]);
        end
        wr(AMC_ADDR_ADV_CONFIG, 8'h04);
        chk({slot0_is_pair, slot0_pos_input, slot0_neg_input}, 8'h41);
        rdc(8'h55, 8'h00);
        $display("config test done");
        wr(AMC_ADDR_DEEP_SLEEP, 8'hff);
        chk({7'h00, ctrl.deep_sleep}, 8'h01);
        rdc(AMC_ADDR_DEEP_SLEEP, 8'h01);
        amc_host_model_inst.wr(AMC_ADDR_TRIGGER, 8'h01);
        @(negedge clk);
        chk({7'h00, pass_active}, 8'h01);
        rdc(AMC_ADDR_ACTIVITY, 8'h01);
        wait_pass();
        chk({6'h00, ctrl.shutdown, ctrl.deep_sleep}, 8'h01);
        chk({7'h00, pass_active}, 8'h00);
        wr(AMC_ADDR_DEEP_SLEEP, 8'h00);
        wr(AMC_ADDR_TRIGGER, 8'h01);
        wait_pass();
        chk({6'h00, ctrl.shutdown, ctrl.deep_sleep}, 8'h02);
        wr(AMC_ADDR_TRIGGER, 8'hfe);
        chk({7'h00, pass_active}, 8'h00);
        $display("trigger test done");
        wr(AMC_ADDR_CONFIG, 8'h01);
        wr(AMC_ADDR_DEEP_SLEEP, 8'h01);
        chk({7'h00, ctrl.deep_sleep}, 8'h00);
        $display("run priority test done");
        wrap_up();
    end
endmodule : tb
